// file: rtl/tmr2_regs.svh
// register offsets, field positions, reset values and overflow count for the timer 2 block
// assumes a 32-bit apb slave with one aligned word per register
`ifndef TMR2_REGS_SVH
`define TMR2_REGS_SVH
// byte offsets
`define TMR2_OFF_CTRL 12'h000
`define TMR2_OFF_STAT 12'h004
`define TMR2_OFF_VALUE 12'h008
`define TMR2_OFF_VALUE_HI 12'h00c
`define TMR2_OFF_RELOAD 12'h010
`define TMR2_OFF_RELOAD_HI 12'h014
`define TMR2_OFF_CAPCOMP 12'h018
`define TMR2_OFF_CAPCOMP_HI 12'h01c
// control field positions
`define TMR2_CTRL_RUN 0
`define TMR2_CTRL_SSHOT 1
`define TMR2_CTRL_GATE 2
`define TMR2_CTRL_CNTSEL 3
`define TMR2_CTRL_DUAL 4
`define TMR2_CTRL_IRQEN 5
`define TMR2_CTRL_CPRL 6
`define TMR2_CTRL_EDGE_LO 8
`define TMR2_CTRL_DIV_LO 12
`define TMR2_CTRL_OE_LO 16
`define TMR2_CTRL_POL_LO 20
// status field positions
`define TMR2_STAT_OVF 0
`define TMR2_STAT_CMP 1
`define TMR2_STAT_OUTCLK 2
// reset values
`define TMR2_RST_CTRL 32'h0000_0000
`define TMR2_RST_WORD16 16'h0000
// all ones count that counts as overflow
`define TMR2_OVF_VALUE 16'hffff
`endif

// file: rtl/tmr2_pkg.sv
// types shared by the timer 2 block
// assumes the constants header is included by users
package tmr2_pkg;
	// operating mode decoded from control bits
	typedef enum logic [2:0] {
		TMR2_RELOAD_CMP,
		TMR2_CAPTURE16,
		TMR2_COUNTER16,
		TMR2_DUAL8_TIMER,
		TMR2_DUAL8_CAPTURE,
		TMR2_DUAL8_COUNTER
	} tmr2_mode_type;
	// control register fields
	typedef struct packed {
		logic [1:0] polarity_field;
		logic [1:0] output_enable_field;
		logic [2:0] prescale_field;
		logic [1:0] edge_function_field;
		logic capture_reload_enable;
		logic timer_irq_enable;
		logic dual_byte_mode_sel;
		logic counter_select;
		logic gate_enable;
		logic single_shot_bit;
		logic run_control;
	} tmr2_ctrl_type;
	// pin outputs as one bundle
	typedef struct packed {
		logic [1:0] level;
		logic [1:0] enable;
	} tmr2_pins_type;
endpackage

// file: rtl/tmr2_core.sv
// timer 2 core: 16-bit reload/compare timer with toggling pwm output on two pins
// assumes a synchronous apb master on clk_i and synchronous pin inputs
`timescale 1ns/100ps
`include "tmr2_regs.svh"

// Behaviour
// - count value register, high byte separately reachable
// - dual 8-bit mode: high byte unwritable, cleared by word writes, reads zero at its own offset
// - reload register with separate high-byte access
// - capture/compare register with high-byte access
// - decode capture, counter and dual modes
// - reload/compare mode when dual, counter select and edge clear
// - count only while run or single-shot bit set
// - timer ticks at prescaled system clock
// - count up, reload on overflow
// - overflow flag set at all-ones count
// - irq while overflow flag set and enabled
// - compare match sets status flag, may interrupt
// - compare outside counting range never matches
// - output clock toggles after match or overflow
// - enable bits route output clock to pins
// - polarity bit xor'ed onto pin output
// - polarity takes effect on enable rising
// - single shot runs until overflow, self-clears
// - gating blocks clock when pin equals polarity and primary output is disabled
module tmr2_core #(
	parameter int CNT_W = 16, // timer width
	parameter logic [63:0] DIV_TABLE = 64'h0000_0000_7654_3210 // log2 ratio per code, 8 x 4 bits (lower half)
) (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic ce_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input wire logic primary_pin_i,
	output logic primary_pin_o,
	output logic primary_pin_oe_o,
	output logic secondary_pin_o,
	output logic secondary_pin_oe_o,
	output logic irq_o
);
	tmr2_pkg::tmr2_ctrl_type ctrl_q; // control bits
	tmr2_pkg::tmr2_mode_type mode; // decoded mode
	tmr2_pkg::tmr2_pins_type pins_q; // registered pin drive
	logic [CNT_W-1:0] value_q; // count value register
	logic [CNT_W-1:0] reload_q; // reload value register
	logic [CNT_W-1:0] capcomp_q; // capture/compare register
	logic ovf_flag_q; // overflow flag
	logic cmp_flag_q; // compare status flag
	logic outclk_q; // internal output clock
	logic toggle_q; // toggle pending for next cycle
	logic [1:0] pol_eff_q; // polarity latched on enable rising
	logic [1:0] oe_prev_q; // enable bits one cycle ago
	logic [7:0] pre_q; // prescale counter
	logic tick; // prescaled timer tick
	logic gated; // gate blocks clock
	logic running; // run or single shot
	logic at_ovf; // count at overflow value
	logic in_range; // compare value inside counting range
	logic cmp_hit; // compare match on this tick
	logic ovf_hit; // overflow on this tick
	logic wr_en; // apb write strobe
	logic [31:0] rd_mux; // read data before register
	logic addr_ok; // mapped address

	// divide ratio lookup, used only for the tick compare of the prescaler
	function automatic logic [7:0] div_mask(input logic [2:0] code);
		logic [3:0] sh;
		sh = DIV_TABLE[code*4 +: 4];
		div_mask = 8'((9'h001 << sh) - 9'h001);
	endfunction

	// decode mode from control bits
	always_comb begin
		case ({ctrl_q.dual_byte_mode_sel, ctrl_q.counter_select, ctrl_q.edge_function_field != 2'h0})
			3'b000: mode = tmr2_pkg::TMR2_RELOAD_CMP;
			3'b001: mode = tmr2_pkg::TMR2_CAPTURE16;
			3'b011: mode = tmr2_pkg::TMR2_COUNTER16;
			3'b010: mode = tmr2_pkg::TMR2_COUNTER16; // counter with no edge holds
			3'b100: mode = tmr2_pkg::TMR2_DUAL8_TIMER;
			3'b101: mode = tmr2_pkg::TMR2_DUAL8_CAPTURE;
			3'b110: mode = tmr2_pkg::TMR2_DUAL8_COUNTER;
			3'b111: mode = tmr2_pkg::TMR2_DUAL8_COUNTER;
			default: mode = tmr2_pkg::TMR2_RELOAD_CMP;
		endcase
	end

	// apb slave is always ready, no wait states
	assign pready_o = 1'b1;
	assign wr_en = psel_i & penable_i & pwrite_i & ce_i;
	assign addr_ok = (paddr_i[11:5] == 7'h00) && (paddr_i[1:0] == 2'h0);
	assign pslverr_o = psel_i & penable_i & ~addr_ok;

	// gating, run and tick conditions
	assign gated = ctrl_q.gate_enable & ~ctrl_q.output_enable_field[0]
		& (primary_pin_i == ctrl_q.polarity_field[0]);
	assign running = (ctrl_q.run_control | ctrl_q.single_shot_bit) & ~gated;
	assign tick = running && (mode == tmr2_pkg::TMR2_RELOAD_CMP)
		&& ((pre_q & div_mask(ctrl_q.prescale_field)) == div_mask(ctrl_q.prescale_field));
	assign at_ovf = value_q == `TMR2_OVF_VALUE;
	assign in_range = capcomp_q >= reload_q;
	assign ovf_hit = tick & at_ovf;
	assign cmp_hit = tick & in_range & (value_q == capcomp_q);

	// prescale counter free runs while running
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			pre_q <= 8'h00;
		end else if (ce_i) begin
			if (running) begin
				pre_q <= pre_q + 8'h01;
			end else begin
				pre_q <= 8'h00;
			end
		end
	end

	// control register with single-shot self-clear
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			ctrl_q <= tmr2_pkg::tmr2_ctrl_type'(`TMR2_RST_CTRL);
		end else if (ce_i) begin
			if (wr_en && paddr_i == `TMR2_OFF_CTRL) begin
				ctrl_q.run_control <= pwdata_i[`TMR2_CTRL_RUN];
				ctrl_q.single_shot_bit <= pwdata_i[`TMR2_CTRL_SSHOT] | (ctrl_q.single_shot_bit & ~ovf_hit);
				ctrl_q.gate_enable <= pwdata_i[`TMR2_CTRL_GATE];
				ctrl_q.counter_select <= pwdata_i[`TMR2_CTRL_CNTSEL];
				ctrl_q.dual_byte_mode_sel <= pwdata_i[`TMR2_CTRL_DUAL];
				ctrl_q.timer_irq_enable <= pwdata_i[`TMR2_CTRL_IRQEN];
				ctrl_q.capture_reload_enable <= pwdata_i[`TMR2_CTRL_CPRL];
				ctrl_q.edge_function_field <= pwdata_i[`TMR2_CTRL_EDGE_LO +: 2];
				ctrl_q.prescale_field <= pwdata_i[`TMR2_CTRL_DIV_LO +: 3];
				ctrl_q.output_enable_field <= pwdata_i[`TMR2_CTRL_OE_LO +: 2];
				ctrl_q.polarity_field <= pwdata_i[`TMR2_CTRL_POL_LO +: 2];
			end else if (ovf_hit) begin
				ctrl_q.single_shot_bit <= 1'b0;
			end
		end
	end

	// count value: software loads, timer counts and reloads
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			value_q <= `TMR2_RST_WORD16;
		end else if (ce_i) begin
			if (wr_en && paddr_i == `TMR2_OFF_VALUE) begin
				value_q <= pwdata_i[CNT_W-1:0];
				if (ctrl_q.dual_byte_mode_sel) begin
					value_q[CNT_W-1:8] <= 8'h00;
				end
			end else if (wr_en && paddr_i == `TMR2_OFF_VALUE_HI) begin
				if (!ctrl_q.dual_byte_mode_sel) begin
					value_q[CNT_W-1:8] <= pwdata_i[7:0];
				end
			end else if (ovf_hit) begin
				value_q <= reload_q;
			end else if (tick) begin
				value_q <= value_q + 16'h0001;
			end
		end
	end

	// reload and compare registers, full word and high byte
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			reload_q <= `TMR2_RST_WORD16;
			capcomp_q <= `TMR2_RST_WORD16;
		end else if (ce_i && wr_en) begin
			case (paddr_i)
				`TMR2_OFF_RELOAD: reload_q <= pwdata_i[CNT_W-1:0];
				`TMR2_OFF_RELOAD_HI: reload_q[CNT_W-1:8] <= pwdata_i[7:0];
				`TMR2_OFF_CAPCOMP: capcomp_q <= pwdata_i[CNT_W-1:0];
				`TMR2_OFF_CAPCOMP_HI: capcomp_q[CNT_W-1:8] <= pwdata_i[7:0];
				default: begin
				end
			endcase
		end
	end

	// sticky flags: set wins over a software clear (write one to clear)
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			ovf_flag_q <= 1'b0;
			cmp_flag_q <= 1'b0;
		end else if (ce_i) begin
			if (ovf_hit) begin
				ovf_flag_q <= 1'b1;
			end else if (wr_en && paddr_i == `TMR2_OFF_STAT && pwdata_i[`TMR2_STAT_OVF]) begin
				ovf_flag_q <= 1'b0;
			end
			if (cmp_hit) begin
				cmp_flag_q <= 1'b1;
			end else if (wr_en && paddr_i == `TMR2_OFF_STAT && pwdata_i[`TMR2_STAT_CMP]) begin
				cmp_flag_q <= 1'b0;
			end
		end
	end

	// interrupt request level
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			irq_o <= 1'b0;
		end else if (ce_i) begin
			irq_o <= ctrl_q.timer_irq_enable & (ovf_flag_q | cmp_flag_q);
		end
	end

	// output clock toggles the cycle after a match or overflow, once if both coincide
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			toggle_q <= 1'b0;
			outclk_q <= 1'b0;
		end else if (ce_i) begin
			toggle_q <= cmp_hit | ovf_hit;
			if (toggle_q) begin
				outclk_q <= ~outclk_q;
			end
		end
	end

	// polarity captured only when an enable bit rises
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			oe_prev_q <= 2'h0;
			pol_eff_q <= 2'h0;
		end else if (ce_i) begin
			oe_prev_q <= ctrl_q.output_enable_field;
			for (int i = 0; i < 2; i++) begin
				if (ctrl_q.output_enable_field[i] && !oe_prev_q[i]) begin
					pol_eff_q[i] <= ctrl_q.polarity_field[i];
				end
			end
		end
	end

	// pin drive registers
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			pins_q <= '0;
		end else if (ce_i) begin
			pins_q.enable <= ctrl_q.output_enable_field;
			pins_q.level <= {2{outclk_q}} ^ pol_eff_q;
		end
	end
	assign primary_pin_o = pins_q.level[0];
	assign primary_pin_oe_o = pins_q.enable[0];
	assign secondary_pin_o = pins_q.level[1];
	assign secondary_pin_oe_o = pins_q.enable[1];

	// read mux
	always_comb begin
		rd_mux = 32'h0000_0000;
		case (paddr_i)
			`TMR2_OFF_CTRL: begin
				rd_mux[`TMR2_CTRL_RUN] = ctrl_q.run_control;
				rd_mux[`TMR2_CTRL_SSHOT] = ctrl_q.single_shot_bit;
				rd_mux[`TMR2_CTRL_GATE] = ctrl_q.gate_enable;
				rd_mux[`TMR2_CTRL_CNTSEL] = ctrl_q.counter_select;
				rd_mux[`TMR2_CTRL_DUAL] = ctrl_q.dual_byte_mode_sel;
				rd_mux[`TMR2_CTRL_IRQEN] = ctrl_q.timer_irq_enable;
				rd_mux[`TMR2_CTRL_CPRL] = ctrl_q.capture_reload_enable;
				rd_mux[`TMR2_CTRL_EDGE_LO +: 2] = ctrl_q.edge_function_field;
				rd_mux[`TMR2_CTRL_DIV_LO +: 3] = ctrl_q.prescale_field;
				rd_mux[`TMR2_CTRL_OE_LO +: 2] = ctrl_q.output_enable_field;
				rd_mux[`TMR2_CTRL_POL_LO +: 2] = ctrl_q.polarity_field;
			end
			`TMR2_OFF_STAT: begin
				rd_mux[`TMR2_STAT_OVF] = ovf_flag_q;
				rd_mux[`TMR2_STAT_CMP] = cmp_flag_q;
				rd_mux[`TMR2_STAT_OUTCLK] = outclk_q;
			end
			`TMR2_OFF_VALUE: rd_mux[CNT_W-1:0] = value_q;
			`TMR2_OFF_VALUE_HI: rd_mux[7:0] = ctrl_q.dual_byte_mode_sel ? 8'h00 : value_q[CNT_W-1:8];
			`TMR2_OFF_RELOAD: rd_mux[CNT_W-1:0] = reload_q;
			`TMR2_OFF_RELOAD_HI: rd_mux[7:0] = reload_q[CNT_W-1:8];
			`TMR2_OFF_CAPCOMP: rd_mux[CNT_W-1:0] = capcomp_q;
			`TMR2_OFF_CAPCOMP_HI: rd_mux[7:0] = capcomp_q[CNT_W-1:8];
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	// read data register, loaded in the setup cycle of a read
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			prdata_o <= 32'h0000_0000;
		end else if (ce_i && psel_i && !penable_i && !pwrite_i) begin
			prdata_o <= rd_mux;
		end
	end
endmodule

// file: tb/tmr2_sva.sv
// checker for the timer 2 core, bound to its ports
// assumes one clock domain and the synchronous active-low reset
`timescale 1ns/100ps
`include "tmr2_regs.svh"
module tmr2_sva (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic ce_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic [31:0] prdata_o,
	input wire logic irq_o,
	input wire logic primary_pin_o,
	input wire logic primary_pin_oe_o,
	input wire logic secondary_pin_o,
	input wire logic secondary_pin_oe_o
);
	logic wr, rs, cw, en_q, run_q, go_q, dual_q; // decode and control shadow
	logic [1:0] oe_q, idle_q; // enables, cycles since stop
	logic [7:0] rlh_q; // reload high byte shadow
	assign wr = psel_i & penable_i & pwrite_i & ce_i;
	assign rs = psel_i & ~penable_i & ~pwrite_i;
	assign cw = wr && paddr_i == `TMR2_OFF_CTRL;
	// shadow of control bits as software wrote them
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			{en_q, run_q, go_q, dual_q, oe_q} <= 6'h00;
		end else if (cw) begin
			en_q <= pwdata_i[`TMR2_CTRL_IRQEN];
			run_q <= pwdata_i[`TMR2_CTRL_RUN];
			go_q <= pwdata_i[`TMR2_CTRL_RUN] | pwdata_i[`TMR2_CTRL_SSHOT];
			dual_q <= pwdata_i[`TMR2_CTRL_DUAL];
			oe_q <= pwdata_i[`TMR2_CTRL_OE_LO+:2];
		end
	end
	// reload high byte, reachable from both addresses
	always_ff @(posedge clk_i) begin
		if (!rstn_i) rlh_q <= 8'h00;
		else if (wr && paddr_i == `TMR2_OFF_RELOAD) rlh_q <= pwdata_i[15:8];
		else if (wr && paddr_i == `TMR2_OFF_RELOAD_HI) rlh_q <= pwdata_i[7:0];
	end
	// stopped cycles, saturating; pipeline tail needs three
	always_ff @(posedge clk_i) begin
		if (!rstn_i || cw || go_q) idle_q <= 2'h0;
		else if (idle_q != 2'h3) idle_q <= idle_q + 2'h1;
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rstn_i);
	chk_reset_quiet: assert property ($rose(rstn_i) |-> !irq_o && !primary_pin_oe_o && !secondary_pin_oe_o)
		else $error("outputs active right after reset");
	chk_irq_needs_en: assert property (!en_q && !$past(en_q) |-> !irq_o)
		else $error("irq high with interrupts disabled");
	chk_oe_primary: assert property (cw |-> ##2 primary_pin_oe_o == oe_q[0])
		else $error("primary enable not following control");
	chk_oe_secondary: assert property (cw |-> ##2 secondary_pin_oe_o == oe_q[1])
		else $error("secondary enable not following control");
	chk_stopped_still: assert property (idle_q == 2'h3 |-> $stable(primary_pin_o) && $stable(secondary_pin_o))
		else $error("pin moved while timer stopped");
	chk_dual_hi_zero: assert property (rs && paddr_i == `TMR2_OFF_VALUE_HI && dual_q |=> prdata_o[7:0] == 8'h00)
		else $error("value high byte nonzero in dual mode");
	chk_reload_hi_read: assert property (rs && paddr_i == `TMR2_OFF_RELOAD_HI |=> prdata_o[7:0] == rlh_q)
		else $error("reload high byte readback wrong");
	chk_run_readback: assert property (rs && paddr_i == `TMR2_OFF_CTRL |=> prdata_o[0] == run_q)
		else $error("run bit readback wrong");
	cover property (cw && pwdata_i[`TMR2_CTRL_SSHOT]);
	cover property ($rose(irq_o));
	cover property ($rose(primary_pin_oe_o));
endmodule
bind tmr2_core tmr2_sva u_sva (.clk_i(clk_i), .rstn_i(rstn_i), .ce_i(ce_i), .psel_i(psel_i), .penable_i(penable_i),
	.pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .irq_o(irq_o),
	.primary_pin_o(primary_pin_o), .primary_pin_oe_o(primary_pin_oe_o), .secondary_pin_o(secondary_pin_o),
	.secondary_pin_oe_o(secondary_pin_oe_o));

// file: tb/tmr2_pin_board.sv
// board model for one timer pin and its pad
// assumes the core's enable is high while it drives the pad
`timescale 1ns/100ps
module tmr2_pin_board (
	input wire logic clk_i,
	input wire logic clr_i,
	input wire logic oe_i,
	input wire logic lvl_i,
	input wire logic ext_i,
	output logic pin_o,
	output int edges_o
);
	logic last_q; // pad level one cycle ago
	// pad: core level when enabled, else board source
	assign pin_o = oe_i ? lvl_i : ext_i;
	// count level changes while the core drives
	always_ff @(posedge clk_i) begin
		last_q <= pin_o;
		if (clr_i) edges_o <= 0;
		else if (oe_i && pin_o !== last_q) edges_o <= edges_o + 1;
	end
endmodule

// file: tb/tb_top.sv
// self-checking bench for the timer 2 core with board pin models
// assumes a zero-wait apb slave and registered pin outputs
`timescale 1ns/100ps
`include "tmr2_regs.svh"
module tb_top;
	localparam logic [11:0] CT = `TMR2_OFF_CTRL, ST = `TMR2_OFF_STAT, VL = `TMR2_OFF_VALUE, RL = `TMR2_OFF_RELOAD;
	logic clk_i, rstn_i, ce, psel, pen, pwr, e, oc, ext, clr, pready, pslverr, irq, p_o, p_oe, s_o, s_oe, p_in;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, r;
	logic [56:0] rows [7]; // write addr, data, read addr, error, expected
	int err_total, check_count, cyc, pe, se;
	tmr2_core dut (.clk_i(clk_i), .rstn_i(rstn_i), .ce_i(ce), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
		.paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
		.primary_pin_i(p_in), .primary_pin_o(p_o), .primary_pin_oe_o(p_oe), .secondary_pin_o(s_o),
		.secondary_pin_oe_o(s_oe), .irq_o(irq));
	tmr2_pin_board pb (.clk_i(clk_i), .clr_i(clr), .oe_i(p_oe), .lvl_i(p_o), .ext_i(ext), .pin_o(p_in), .edges_o(pe));
	tmr2_pin_board sb (.clk_i(clk_i), .clr_i(clr), .oe_i(s_oe), .lvl_i(s_o), .ext_i(1'b0), .pin_o(), .edges_o(se));
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			err_total++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// one apb transfer, then an idle cycle
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_i);
		pen <= 1'b1;
		do @(posedge clk_i); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic rd(input logic [11:0] a);
		apb(1'b0, a, 32'h0);
	endtask
	task automatic summarize;
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	initial begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end
	// hang guard
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			summarize();
		end
	end
	initial begin
		{rstn_i, psel, pen, pwr, ext, clr} = 6'h00;
		ce = 1'b1;
		paddr = 12'h000;
		pwdata = 32'h0;
		rows = '{{RL, 16'h1234, RL, 1'b0, 16'h1234}, {`TMR2_OFF_RELOAD_HI, 16'h00ab, RL, 1'b0, 16'hab34},
			{`TMR2_OFF_CAPCOMP, 16'h5678, `TMR2_OFF_CAPCOMP_HI, 1'b0, 16'h0056},
			{`TMR2_OFF_CAPCOMP_HI, 16'h00cd, `TMR2_OFF_CAPCOMP, 1'b0, 16'hcd78},
			{VL, 16'h9abc, `TMR2_OFF_VALUE_HI, 1'b0, 16'h009a}, {`TMR2_OFF_VALUE_HI, 16'h0012, VL, 1'b0, 16'h12bc},
			{12'h020, 16'h00ff, 12'h020, 1'b1, 16'h0000}};
		repeat (4) @(posedge clk_i);
		rstn_i <= 1'b1;
		@(posedge clk_i);
		check({irq, p_oe, s_oe}, 3'h0);
		rd(CT);
		check(r, `TMR2_RST_CTRL);
		$display("reset test done");
		// plain register rows
		foreach (rows[i]) begin
			apb(1'b1, rows[i][56:45], {16'h0, rows[i][44:29]});
			rd(rows[i][28:17]);
			check({e, r[15:0]}, rows[i][16:0]);
		end
		apb(1'b1, CT, 32'h10);
		apb(1'b1, `TMR2_OFF_VALUE_HI, 32'h77);
		rd(`TMR2_OFF_VALUE_HI);
		check(r, 32'h0);
		apb(1'b1, CT, 32'h0);
		$display("register test done");
		// compare outside and inside the counting range
		apb(1'b1, RL, 32'hfff0);
		for (int i = 0; i < 2; i++) begin
			apb(1'b1, VL, 32'hfff0);
			apb(1'b1, `TMR2_OFF_CAPCOMP, i ? 32'hfff8 : 32'h0010);
			apb(1'b1, ST, 32'h3);
			apb(1'b1, CT, 32'h21);
			repeat (40) @(posedge clk_i);
			rd(ST);
			check(r[1:0], i ? 2'h3 : 2'h1);
			check(irq, 1'b1);
			apb(1'b1, CT, 32'h0);
		end
		$display("compare test done");
		// one toggle per period when compare equals overflow, for prescale codes 0 to 2
		apb(1'b1, `TMR2_OFF_CAPCOMP, 32'hffff); // compare only changed while stopped
		for (int c = 0; c < 3; c++) begin
			apb(1'b1, VL, 32'hfff0);
			clr <= 1'b1;
			apb(1'b1, CT, 32'h3_0001 | (c << 12));
			clr <= 1'b0;
			repeat (320) @(posedge clk_i);
			apb(1'b1, CT, 32'h3_0000);
			check(pe >= (20 >> c) - 1 && pe <= (20 >> c) + 1, 1'b1);
			check(se, pe);
		end
		$display("toggle test done");
		// polarity taken only at enable rise
		apb(1'b1, CT, 32'h30_0000);
		rd(ST);
		oc = r[`TMR2_STAT_OUTCLK];
		apb(1'b1, CT, 32'h33_0000);
		repeat (2) @(posedge clk_i);
		check({p_o, s_o}, {2{~oc}});
		apb(1'b1, CT, 32'h03_0000);
		repeat (2) @(posedge clk_i);
		check({p_o, s_o}, {2{~oc}});
		$display("polarity test done");
		// single shot runs to one overflow then stops
		apb(1'b1, CT, 32'h0);
		apb(1'b1, RL, 32'hff00);
		apb(1'b1, VL, 32'hfff0);
		apb(1'b1, CT, 32'h2);
		repeat (40) @(posedge clk_i);
		rd(CT);
		check(r[1], 1'b0);
		rd(VL);
		check(r, 32'hff00);
		// gated while pad level equals polarity bit 0
		apb(1'b1, VL, 32'hfff0);
		apb(1'b1, CT, 32'h5);
		repeat (20) @(posedge clk_i);
		rd(VL);
		check(r, 32'hfff0);
		ext <= 1'b1;
		repeat (4) @(posedge clk_i);
		rd(VL);
		check(r !== 32'hfff0, 1'b1);
		// clock enable low freezes state and blocks writes
		apb(1'b1, CT, 32'h0);
		apb(1'b1, VL, 32'h2222);
		ce <= 1'b0;
		apb(1'b1, VL, 32'h1111);
		ce <= 1'b1;
		rd(VL);
		check(r, 32'h2222);
		$display("shot and gate test done");
		summarize();
	end
endmodule
